// [hw/channel_gain_normalizer.sv]
// Command interpreter that normalizes per-channel gain from sensitivity, output level and expected input.
`timescale 1ns/1ps

// What this block does
// R1 - N command stores channel sensitivity, recomputes gain
// R2 - N0 sets rack output level 1 to 10
// R3 - Gain is level over sensitivity times expected
// R4 - Gain checked against fitted fine-gain range
// R5 - In range: update gains, reply acknowledgement
// R6 - Out of range: reply gain range error
// R7 - N query returns channel, sensitivity, level
// R8 - E command stores channel expected input
// R9 - E query adds expected input to reply
// R10 - Defaults 1000 mV, 1 V, 1 unit
// R11 - Memory option keeps settings across reset
// R12 - Without memory option reset loads defaults
// R13 - Gain rounded to fitted stage resolution
// R14 - Host sends one command, awaits reply
module channel_gain_normalizer (
	input  wire logic                        clk,
	input  wire logic                        resetn,
	input  wire logic                        expanded_fitted,
	input  wire logic                        memdef_fitted,
	input  wire logic                        cmd_valid,
	output logic                             cmd_ready,
	input  wire logic                        cmd_kind,
	input  wire logic                        cmd_query,
	input  wire logic [gain_pkg::CHAN_W-1:0]  cmd_chan,
	input  wire logic [gain_pkg::VALUE_W-1:0] cmd_value,
	output logic                             gain_we,
	output logic      [gain_pkg::CHAN_W-1:0]  gain_chan,
	output logic      [gain_pkg::GAIN_W-1:0]  gain_value,
	output logic                             reply_valid,
	output logic      [2:0]                  reply_code,
	output logic      [gain_pkg::CHAN_W-1:0]  reply_chan,
	output logic      [gain_pkg::VALUE_W-1:0] reply_sens,
	output logic      [gain_pkg::LEVEL_W-1:0] reply_level,
	output logic      [gain_pkg::VALUE_W-1:0] reply_expect
);
	typedef struct packed {
		gain_pkg::phase_type                             phase;
		logic [15:0][gain_pkg::VALUE_W-1:0]              sens;
		logic [15:0][gain_pkg::VALUE_W-1:0]              expect_in;
		logic [gain_pkg::LEVEL_W-1:0]                    level;
		logic [gain_pkg::LEVEL_W-1:0]                    level_kept;
		gain_pkg::cmd_kind_type                          kind;
		logic                                            all_ch;
		logic [3:0]                                      idx;
		logic [3:0]                                      tgt;
		logic [gain_pkg::VALUE_W-1:0]                    value;
		gain_pkg::reply_code_type                        code;
		logic [gain_pkg::PROD_W-1:0]                     prod;
		logic                                            div_start;
		logic                                            gain_we;
		logic [gain_pkg::CHAN_W-1:0]                     gain_chan;
		logic [gain_pkg::GAIN_W-1:0]                     gain_value;
		logic                                            reply_valid;
		logic [gain_pkg::CHAN_W-1:0]                     reply_chan;
		logic [gain_pkg::VALUE_W-1:0]                    reply_sens;
		logic [gain_pkg::LEVEL_W-1:0]                    reply_level;
		logic [gain_pkg::VALUE_W-1:0]                    reply_expect;
	} state_type;

	state_type                     st_reg;
	state_type                     st_next;
	logic [1:0]                    opt_s;
	logic                          expanded_s;
	logic                          memdef_s;
	logic                          div_done;
	logic [gain_pkg::DIV_W-1:0]     div_quotient;
	logic [gain_pkg::DIV_W-1:0]     div_dividend;

	option_sync u_sync (
		.clk    (clk),
		.pins   ({memdef_fitted, expanded_fitted}),
		.synced (opt_s)
	);
	assign expanded_s = opt_s[0];
	assign memdef_s   = opt_s[1];

	// Adding half the divisor turns the truncating quotient into a rounded one.
	assign div_dividend = gain_pkg::DIV_W'(gain_pkg::numerator(st_reg.level, expanded_s))
		+ gain_pkg::DIV_W'(st_reg.prod >> 1); // see R13

	gain_divider u_div (
		.clk      (clk),
		.resetn   (resetn),
		.start    (st_reg.div_start),
		.dividend (div_dividend),
		.divisor  (st_reg.prod),
		.done     (div_done),
		.quotient (div_quotient)
	);

	// Channel numbers on the ports run from 1, the stored tables from 0.
	function automatic logic [3:0] index_of(input logic [gain_pkg::CHAN_W-1:0] chan);
		index_of = 4'(chan - 5'h01);
	endfunction : index_of

	function automatic logic [gain_pkg::CHAN_W-1:0] chan_of(input logic [3:0] idx);
		chan_of = 5'({1'b0, idx} + 5'h01);
	endfunction : chan_of

	always_comb begin
		logic                         chan_ok;
		logic                         last;
		logic [gain_pkg::VALUE_W-1:0] cs;
		logic [gain_pkg::VALUE_W-1:0] cx;
		logic [gain_pkg::LEVEL_W-1:0] cl;
		logic [gain_pkg::PROD_W-1:0]  p;
		chan_ok = (cmd_chan >= 5'h01) && (cmd_chan <= 5'h10);
		last    = st_reg.all_ch ? (st_reg.idx == 4'hF) : 1'b1;
		cs      = '0;
		cx      = '0;
		cl      = '0;
		p       = '0;
		st_next = st_reg;
		st_next.div_start   = 1'b0;
		st_next.gain_we     = 1'b0;
		st_next.reply_valid = 1'b0;
		case (st_reg.phase)
			gain_pkg::PH_IDLE: begin
				if (cmd_valid) begin
					st_next.kind   = gain_pkg::cmd_kind_type'(cmd_kind);
					st_next.value  = cmd_value;
					st_next.tgt    = index_of(cmd_chan);
					st_next.idx    = index_of(cmd_chan);
					st_next.all_ch = 1'b0;
					if (cmd_chan == 5'h00 && cmd_kind == gain_pkg::CMD_SENS && !cmd_query) begin
						if (cmd_value >= 24'(gain_pkg::LEVEL_MIN) && cmd_value <= 24'(gain_pkg::LEVEL_MAX)) begin
							st_next.all_ch = 1'b1; // see R2
							st_next.idx    = 4'h0;
							st_next.phase  = gain_pkg::PH_CHECK;
						end else begin
							st_next.code  = gain_pkg::REPLY_BAD;
							st_next.phase = gain_pkg::PH_REPLY;
						end
					end else if (!chan_ok) begin
						st_next.code  = gain_pkg::REPLY_BAD;
						st_next.phase = gain_pkg::PH_REPLY;
					end else if (cmd_query) begin
						st_next.code  = (cmd_kind == gain_pkg::CMD_SENS) ? gain_pkg::REPLY_SENS
							: gain_pkg::REPLY_EXPECT; // see R7, see R9
						st_next.phase = gain_pkg::PH_REPLY;
					end else begin
						st_next.phase = gain_pkg::PH_CHECK;
					end
				end
			end
			gain_pkg::PH_CHECK: begin
				// Candidate values are checked for every affected channel before anything is committed.
				cs = (st_reg.kind == gain_pkg::CMD_SENS && !st_reg.all_ch && st_reg.idx == st_reg.tgt)
					? st_reg.value : st_reg.sens[st_reg.idx];
				cx = (st_reg.kind == gain_pkg::CMD_EXPECT && st_reg.idx == st_reg.tgt)
					? st_reg.value : st_reg.expect_in[st_reg.idx];
				cl = st_reg.all_ch ? st_reg.value[gain_pkg::LEVEL_W-1:0] : st_reg.level;
				p  = gain_pkg::prod_of(cs, cx);
				if (!gain_pkg::in_range(cl, p, expanded_s)) begin
					st_next.code  = gain_pkg::REPLY_RANGE_ERR; // see R4, see R6
					st_next.phase = gain_pkg::PH_REPLY;
				end else if (last) begin
					if (st_reg.all_ch) begin
						st_next.level = st_reg.value[gain_pkg::LEVEL_W-1:0]; // see R2
					end else if (st_reg.kind == gain_pkg::CMD_SENS) begin
						st_next.sens[st_reg.tgt] = st_reg.value; // see R1
					end else begin
						st_next.expect_in[st_reg.tgt] = st_reg.value; // see R8
					end
					st_next.idx   = st_reg.all_ch ? 4'h0 : st_reg.tgt;
					st_next.phase = gain_pkg::PH_DIV_START;
				end else begin
					st_next.idx = st_reg.idx + 4'h1;
				end
			end
			gain_pkg::PH_DIV_START: begin
				st_next.prod      = gain_pkg::prod_of(st_reg.sens[st_reg.idx], st_reg.expect_in[st_reg.idx]); // see R3
				st_next.div_start = 1'b1;
				st_next.phase     = gain_pkg::PH_DIV_WAIT;
			end
			gain_pkg::PH_DIV_WAIT: begin
				if (div_done) begin
					st_next.gain_we    = 1'b1; // see R5
					st_next.gain_chan  = chan_of(st_reg.idx);
					st_next.gain_value = expanded_s ? div_quotient[gain_pkg::GAIN_W-1:0]
						: 18'(div_quotient[gain_pkg::GAIN_W-1:0] * gain_pkg::STD_STEP); // see R13
					if (last) begin
						st_next.code  = gain_pkg::REPLY_ACK;
						st_next.phase = gain_pkg::PH_REPLY;
					end else begin
						st_next.idx   = st_reg.idx + 4'h1;
						st_next.phase = gain_pkg::PH_DIV_START;
					end
				end
			end
			gain_pkg::PH_REPLY: begin
				st_next.reply_valid  = 1'b1;
				st_next.reply_chan   = st_reg.all_ch ? 5'h00 : chan_of(st_reg.tgt);
				st_next.reply_sens   = st_reg.sens[st_reg.tgt]; // see R7
				st_next.reply_level  = st_reg.level;
				st_next.reply_expect = st_reg.expect_in[st_reg.tgt]; // see R9
				st_next.phase        = gain_pkg::PH_IDLE;
			end
			default: begin
				st_next.phase = gain_pkg::PH_IDLE;
			end
		endcase
		st_next.level_kept = st_next.level;
		if (!resetn) begin
			// A command cut by reset in its check commits nothing; one cut after PH_CHECK has already committed its new setting.
			st_next.sens        = st_reg.sens;
			st_next.expect_in   = st_reg.expect_in;
			st_next.level       = st_reg.level;
			st_next.level_kept  = st_reg.level_kept;
			st_next.phase       = gain_pkg::PH_IDLE;
			st_next.div_start   = 1'b0;
			st_next.gain_we     = 1'b0;
			st_next.reply_valid = 1'b0;
			// Stored settings survive reset only when the memory option is fitted.
			if (!memdef_s) begin // see R11, see R12
				st_next.sens      = {16{gain_pkg::SENS_DEFAULT}}; // see R10
				st_next.expect_in = {16{gain_pkg::EXPECT_DEFAULT}};
				st_next.level     = gain_pkg::LEVEL_DEFAULT;
			end
		end
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	// Commands are only taken in idle; the host waits for each reply.
	assign cmd_ready    = (st_reg.phase == gain_pkg::PH_IDLE); // see R14
	assign gain_we      = st_reg.gain_we;
	assign gain_chan    = st_reg.gain_chan;
	assign gain_value   = st_reg.gain_value;
	assign reply_valid  = st_reg.reply_valid;
	assign reply_code   = st_reg.code;
	assign reply_chan   = st_reg.reply_chan;
	assign reply_sens   = st_reg.reply_sens;
	assign reply_level  = st_reg.reply_level;
	assign reply_expect = st_reg.reply_expect;

	logic [71:0] chk_lhs;
	logic [71:0] chk_rhs;
	logic [71:0] chk_half;
	assign chk_lhs  = 72'(expanded_s ? st_reg.gain_value : st_reg.gain_value / gain_pkg::STD_STEP) * 72'(st_reg.prod);
	assign chk_rhs  = 72'(gain_pkg::numerator(st_reg.level, expanded_s));
	assign chk_half = 72'(st_reg.prod >> 1);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_cmd_taken;
		cmd_valid && cmd_ready;
	endsequence

	sequence s_reply;
		reply_valid;
	endsequence

	sequence s_query_taken;
		cmd_valid && cmd_ready && cmd_query && cmd_chan >= 5'h01 && cmd_chan <= 5'h10;
	endsequence

	a_reply_bounded: assert property (s_cmd_taken |-> ##[2:900] s_reply) // see R5
		else $error("command not answered in time");
	a_ack_follows_write: assert property (reply_valid && reply_code == gain_pkg::REPLY_ACK |-> $past(gain_we)) // see R5
		else $error("acknowledge without a gain write");
	a_error_from_check: assert property (reply_valid && reply_code == gain_pkg::REPLY_RANGE_ERR
		|-> $past(st_reg.phase, 2) == gain_pkg::PH_CHECK && !$past(gain_we)) // see R6
		else $error("range error not raised by the check");
	a_level_limits: assert property (st_reg.level >= gain_pkg::LEVEL_MIN && st_reg.level <= gain_pkg::LEVEL_MAX) // see R2
		else $error("output level outside 1 to 10");
	a_sens_stored: assert property (reply_valid && reply_code == gain_pkg::REPLY_ACK && !st_reg.all_ch
		&& st_reg.kind == gain_pkg::CMD_SENS |-> st_reg.sens[st_reg.tgt] == st_reg.value) // see R1
		else $error("sensitivity not stored");
	a_expect_stored: assert property (reply_valid && reply_code == gain_pkg::REPLY_ACK
		&& st_reg.kind == gain_pkg::CMD_EXPECT |-> st_reg.expect_in[st_reg.tgt] == st_reg.value) // see R8
		else $error("expected input not stored");
	a_sens_query: assert property (reply_valid && reply_code == gain_pkg::REPLY_SENS
		|-> reply_sens == st_reg.sens[st_reg.tgt] && reply_level == st_reg.level) // see R7
		else $error("sensitivity query data wrong");
	a_expect_query: assert property (reply_valid && reply_code == gain_pkg::REPLY_EXPECT
		|-> reply_expect == st_reg.expect_in[st_reg.tgt] && reply_level == st_reg.level) // see R9
		else $error("expected input query data wrong");
	a_gain_limits: assert property (gain_we |-> gain_value <= gain_pkg::GAIN_MAX
		&& gain_value >= (expanded_s ? gain_pkg::GAIN_MIN_EXP : gain_pkg::GAIN_MIN_STD)) // see R4
		else $error("gain written outside fitted range");
	a_gain_ratio: assert property (gain_we |-> chk_lhs <= chk_rhs + chk_half && chk_lhs + chk_half + 72'h1 > chk_rhs) // see R3
		else $error("gain does not match level over product");
	a_std_rounding: assert property (gain_we && !expanded_s |-> gain_value % gain_pkg::STD_STEP == 18'h0_0000) // see R13
		else $error("standard gain not at tenth resolution");
	a_default_load: assert property ($rose(resetn) && !$past(memdef_s) |-> st_reg.level == gain_pkg::LEVEL_DEFAULT
		&& st_reg.sens[0] == gain_pkg::SENS_DEFAULT && st_reg.expect_in[15] == gain_pkg::EXPECT_DEFAULT) // see R10
		else $error("defaults not loaded at reset");
	a_memory_keeps: assert property ($rose(resetn) && $past(memdef_s)
		|-> st_reg.level == st_reg.level_kept) // see R11
		else $error("stored level lost over reset");
	a_busy_refuses: assert property (s_cmd_taken |=> !cmd_ready) // see R14
		else $error("command taken while busy");
	a_query_answer: assert property (s_query_taken |-> ##2 s_reply ##0 (reply_chan == $past(cmd_chan, 2)
		&& reply_code == ($past(cmd_kind, 2) ? gain_pkg::REPLY_EXPECT : gain_pkg::REPLY_SENS))) // see R7, see R9
		else $error("query not answered with its channel");
	a_write_chan: assert property (gain_we && !st_reg.all_ch |-> gain_chan == chan_of(st_reg.tgt)) // see R1
		else $error("gain written to the wrong channel");
	a_write_pulse: assert property (gain_we |=> !gain_we) // see R5
		else $error("gain write longer than one cycle");
	a_reply_pulse: assert property (reply_valid |=> !reply_valid) // see R5
		else $error("reply longer than one cycle");
endmodule : channel_gain_normalizer

// [common/gain_pkg.sv]
// Shared constants, types and arithmetic for the channel gain normalizer.
package gain_pkg;

	localparam int CHANNELS = 16;
	localparam int VALUE_W  = 24;
	localparam int PROD_W   = 48;
	localparam int DIV_W    = 50;
	localparam int GAIN_W   = 18;
	localparam int CHAN_W   = 5;
	localparam int LEVEL_W  = 4;

	// Sensitivity is held in thousandths of a millivolt per unit, expected input in thousandths of a unit.
	localparam logic [VALUE_W-1:0] SENS_DEFAULT   = 24'h0F_4240;
	localparam logic [VALUE_W-1:0] EXPECT_DEFAULT = 24'h00_03E8;
	localparam logic [LEVEL_W-1:0] LEVEL_DEFAULT  = 4'h1;
	localparam logic [LEVEL_W-1:0] LEVEL_MIN      = 4'h1;
	localparam logic [LEVEL_W-1:0] LEVEL_MAX      = 4'hA;

	// Gain numerators: thousandths of gain (expanded) and tenths of gain (standard).
	localparam logic [63:0] SCALE_EXP    = 64'h0000_00E8_D4A5_1000;
	localparam logic [63:0] SCALE_STD    = 64'h0000_0002_540B_E400;
	localparam logic [63:0] SCALE_HI     = 64'h0000_0000_3B9A_CA00;
	localparam logic [63:0] SCALE_LO_EXP = 64'h0000_0918_4E72_A000;
	localparam logic [63:0] HI_MULT      = 64'h0000_0000_0000_00C8;
	localparam logic [63:0] LO_EXP_MULT  = 64'h0000_0000_0000_0019;

	localparam logic [GAIN_W-1:0] GAIN_MAX     = 18'h3_0D40;
	localparam logic [GAIN_W-1:0] GAIN_MIN_STD = 18'h0_0064;
	localparam logic [GAIN_W-1:0] GAIN_MIN_EXP = 18'h0_0002;
	localparam logic [GAIN_W-1:0] STD_STEP     = 18'h0_0064;
	localparam logic [5:0]        DIV_STEPS    = 6'h32;

	typedef enum logic {
		CMD_SENS   = 1'b0,
		CMD_EXPECT = 1'b1
	} cmd_kind_type;

	typedef enum logic [2:0] {
		REPLY_ACK       = 3'b000,
		REPLY_RANGE_ERR = 3'b001,
		REPLY_SENS      = 3'b010,
		REPLY_EXPECT    = 3'b011,
		REPLY_BAD       = 3'b100
	} reply_code_type;

	typedef enum logic [2:0] {
		PH_IDLE      = 3'b000,
		PH_CHECK     = 3'b001,
		PH_DIV_START = 3'b010,
		PH_DIV_WAIT  = 3'b011,
		PH_REPLY     = 3'b100
	} phase_type;

	function automatic logic [PROD_W-1:0] prod_of(input logic [VALUE_W-1:0] a, input logic [VALUE_W-1:0] b);
		prod_of = PROD_W'(a) * PROD_W'(b);
	endfunction : prod_of

	function automatic logic [63:0] numerator(input logic [LEVEL_W-1:0] lvl, input logic expanded);
		numerator = 64'(lvl) * (expanded ? SCALE_EXP : SCALE_STD);
	endfunction : numerator

	// Gain is level*1e9/p; compared without dividing.
	function automatic logic in_range(input logic [LEVEL_W-1:0] lvl, input logic [PROD_W-1:0] p,
			input logic expanded);
		logic hi_ok;
		logic lo_ok;
		hi_ok = (64'(lvl) * SCALE_HI) <= (64'(p) * HI_MULT);
		lo_ok = expanded ? ((64'(p) * LO_EXP_MULT) <= (64'(lvl) * SCALE_LO_EXP))
			: (64'(p) <= (64'(lvl) * SCALE_STD));
		in_range = hi_ok && lo_ok;
	endfunction : in_range

endpackage : gain_pkg

// [hw/option_sync.sv]
// Two-stage synchroniser for the option strap pins.
`timescale 1ns/1ps
module option_sync (
	input  wire logic       clk,
	input  wire logic [1:0] pins,
	output logic      [1:0] synced
);
	typedef struct packed {
		logic [1:0] first;
		logic [1:0] second;
	} state_type;

	state_type st_reg;
	state_type st_next;

	// Left without reset so a strap level seen during reset is already valid.
	always_comb begin
		st_next.first  = pins;
		st_next.second = st_reg.first;
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	assign synced = st_reg.second;
endmodule : option_sync

// [hw/gain_divider.sv]
// Sequential restoring divider for the gain calculation.
`timescale 1ns/1ps
module gain_divider (
	input  wire logic                       clk,
	input  wire logic                       resetn,
	input  wire logic                       start,
	input  wire logic [gain_pkg::DIV_W-1:0]  dividend,
	input  wire logic [gain_pkg::PROD_W-1:0] divisor,
	output logic                            done,
	output logic      [gain_pkg::DIV_W-1:0]  quotient
);
	typedef struct packed {
		logic [5:0]                   cnt;
		logic                         busy;
		logic                         done;
		logic [gain_pkg::PROD_W:0]    rem;
		logic [gain_pkg::DIV_W-1:0]   quo;
		logic [gain_pkg::PROD_W-1:0]  dvs;
	} state_type;

	state_type st_reg;
	state_type st_next;

	always_comb begin
		logic [gain_pkg::PROD_W:0] sh;
		sh = '0;
		st_next = st_reg;
		st_next.done = 1'b0;
		if (start) begin
			st_next.cnt  = gain_pkg::DIV_STEPS;
			st_next.busy = 1'b1;
			st_next.rem  = '0;
			st_next.quo  = dividend;
			st_next.dvs  = divisor;
		end else if (st_reg.busy) begin
			sh = {st_reg.rem[gain_pkg::PROD_W-1:0], st_reg.quo[gain_pkg::DIV_W-1]};
			st_next.quo = {st_reg.quo[gain_pkg::DIV_W-2:0], 1'b0};
			if (sh >= {1'b0, st_reg.dvs}) begin
				st_next.rem    = sh - {1'b0, st_reg.dvs};
				st_next.quo[0] = 1'b1;
			end else begin
				st_next.rem = sh;
			end
			st_next.cnt = st_reg.cnt - 6'h01;
			if (st_reg.cnt == 6'h01) begin
				st_next.busy = 1'b0;
				st_next.done = 1'b1;
			end
		end
		if (!resetn) begin
			st_next = '0;
		end
	end

	always_ff @(posedge clk) begin
		st_reg <= st_next;
	end

	assign done     = st_reg.done;
	assign quotient = st_reg.quo;
endmodule : gain_divider

// [dv/host_model.sv]
// Host computer model that sends one command at a time and collects the echo.
`timescale 1ns/1ps
module host_model (
	input  wire logic        clk,
	input  wire logic        cmd_ready,
	input  wire logic        reply_valid,
	input  wire logic [2:0]  reply_code,
	input  wire logic [4:0]  reply_chan,
	input  wire logic [23:0] reply_sens,
	input  wire logic [3:0]  reply_level,
	input  wire logic [23:0] reply_expect,
	output logic             cmd_valid,
	output logic             cmd_kind,
	output logic             cmd_query,
	output logic      [4:0]  cmd_chan,
	output logic      [23:0] cmd_value
);

	initial begin
		cmd_valid = 1'b0;
		cmd_kind  = 1'b0;
		cmd_query = 1'b0;
		cmd_chan  = 5'h00;
		cmd_value = 24'h00_0000;
	end

	task automatic send(input logic k, input logic q, input logic [4:0] ch, input logic [23:0] v,
			output logic [2:0] code, output logic [4:0] rch, output logic [23:0] rs,
			output logic [3:0] rl, output logic [23:0] re, output logic ok);
		int n;
		n = 0;
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_kind  = k;
		cmd_query = q;
		cmd_chan  = ch;
		cmd_value = v;
		while (cmd_ready !== 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		@(posedge clk);
		@(negedge clk);
		// Released lines carry the inverse so a stale command can never look valid.
		cmd_valid = 1'b0;
		cmd_kind  = ~k;
		cmd_query = ~q;
		cmd_chan  = ~ch;
		cmd_value = ~v;
		// Nothing new is offered until the echo has been seen.
		while (reply_valid !== 1'b1 && n < 4000) begin
			@(negedge clk);
			n++;
		end
		ok   = (reply_valid === 1'b1);
		code = reply_code;
		rch  = reply_chan;
		rs   = reply_sens;
		rl   = reply_level;
		re   = reply_expect;
	endtask : send

endmodule : host_model

// [dv/channel_gain_normalizer_tb.sv]
// Self-checking testbench for the channel gain normalizer.
`timescale 1ns/1ps
module channel_gain_normalizer_tb;

	logic        clk;
	logic        resetn;
	logic        expanded_fitted;
	logic        memdef_fitted;
	logic        cmd_valid;
	logic        cmd_ready;
	logic        cmd_kind;
	logic        cmd_query;
	logic [4:0]  cmd_chan;
	logic [23:0] cmd_value;
	logic        gain_we;
	logic [4:0]  gain_chan;
	logic [17:0] gain_value;
	logic        reply_valid;
	logic [2:0]  reply_code;
	logic [4:0]  reply_chan;
	logic [23:0] reply_sens;
	logic [3:0]  reply_level;
	logic [23:0] reply_expect;
	logic [23:0] m_sens [1:16];
	logic [23:0] m_exp  [1:16];
	logic [3:0]  m_lvl;
	logic        expd;
	logic [4:0]  gq_chan [$];
	logic [17:0] gq_val  [$];
	int          error_cnt;
	int          checked;
	int          cycles;

	channel_gain_normalizer dut (.clk(clk), .resetn(resetn), .expanded_fitted(expanded_fitted),
		.memdef_fitted(memdef_fitted), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_kind(cmd_kind),
		.cmd_query(cmd_query), .cmd_chan(cmd_chan), .cmd_value(cmd_value), .gain_we(gain_we),
		.gain_chan(gain_chan), .gain_value(gain_value), .reply_valid(reply_valid), .reply_code(reply_code),
		.reply_chan(reply_chan), .reply_sens(reply_sens), .reply_level(reply_level), .reply_expect(reply_expect));

	host_model host (.clk(clk), .cmd_ready(cmd_ready), .reply_valid(reply_valid), .reply_code(reply_code),
		.reply_chan(reply_chan), .reply_sens(reply_sens), .reply_level(reply_level),
		.reply_expect(reply_expect), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_query(cmd_query),
		.cmd_chan(cmd_chan), .cmd_value(cmd_value));

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	always @(negedge clk) begin
		if (gain_we === 1'b1) begin
			gq_chan.push_back(gain_chan);
			gq_val.push_back(gain_value);
		end
	end

	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		$display("Comparisons: %0d, mismatches: %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic cmp(input string name, input logic [31:0] expv, input logic [31:0] got);
		checked++;
		if (got !== expv) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, expv, got);
		end
	endtask : cmp

	// Exact range test on the unrounded gain, level*1e9/(sens*expect).
	function automatic logic fits(input logic [3:0] l, input logic [23:0] s, input logic [23:0] e);
		logic [63:0] p;
		logic [63:0] n;
		p = 64'(s) * 64'(e);
		n = 64'(l) * 64'h0000_0000_3B9A_CA00;
		fits = (n <= 64'h0000_0000_0000_00C8 * p) && (expd ? n * 64'h0000_0000_0000_0190 >= p : n * 64'h0000_0000_0000_000A >= p);
	endfunction : fits

	// Gain in thousandths, rounded half up to the fitted stage resolution.
	function automatic logic [17:0] gain_of(input logic [3:0] l, input logic [23:0] s, input logic [23:0] e);
		logic [63:0] q;
		q = 64'(l) * (expd ? 64'h0000_01D1_A94A_2000 : 64'h0000_0004_A817_C800) / (64'(s) * 64'(e));
		gain_of = expd ? 18'((q + 1) / 2) : 18'(((q + 1) / 2) * 64'h0000_0000_0000_0064);
	endfunction : gain_of

	task automatic run(input logic k, input logic q, input logic [4:0] ch, input logic [23:0] v);
		logic [2:0]  ec;
		logic [2:0]  rc;
		logic [4:0]  rch;
		logic [23:0] rs;
		logic [23:0] re;
		logic [3:0]  rl;
		logic        ok;
		logic        good;
		int          lo;
		lo = (ch == 0) ? 1 : ch;
		good = 1'b1;
		gq_chan.delete();
		gq_val.delete();
		if (ch > 16 || (ch == 0 && (q || k)) || (!q && ch == 0 && (v == 0 || v > 10))) begin
			ec = gain_pkg::REPLY_BAD;
		end else if (q) begin
			ec = k ? gain_pkg::REPLY_EXPECT : gain_pkg::REPLY_SENS;
		end else begin
			for (int i = 1; i <= 16; i++) begin
				if (ch == 0 || i == ch) begin
					good &= fits(ch == 0 ? v[3:0] : m_lvl, (!k && ch != 0) ? v : m_sens[i], k ? v : m_exp[i]);
				end
			end
			ec = good ? gain_pkg::REPLY_ACK : gain_pkg::REPLY_RANGE_ERR;
		end
		if (ec == gain_pkg::REPLY_ACK) begin
			if (ch == 0) m_lvl = v[3:0];
			else if (k) m_exp[ch] = v;
			else m_sens[ch] = v;
		end
		host.send(k, q, ch, v, rc, rch, rs, rl, re, ok);
		cmp("reply_seen", 32'h0000_0001, 32'(ok));
		cmp("reply_code", 32'(ec), 32'(rc));
		cmp("gain_count", (ec != gain_pkg::REPLY_ACK) ? 0 : (ch == 0) ? 16 : 1, 32'(gq_chan.size()));
		for (int i = 0; i < gq_chan.size(); i++) begin
			cmp("gain_chan", 32'(lo + i), 32'(gq_chan[i]));
			cmp("gain_value", 32'(gain_of(m_lvl, m_sens[lo + i], m_exp[lo + i])), 32'(gq_val[i]));
		end
		if (ec == gain_pkg::REPLY_ACK || ec == gain_pkg::REPLY_SENS || ec == gain_pkg::REPLY_EXPECT) begin
			cmp("reply_chan", 32'(ch), 32'(rch));
			cmp("reply_level", 32'(m_lvl), 32'(rl));
			if (ch != 0) begin
				cmp("reply_sens", 32'(m_sens[ch]), 32'(rs));
				cmp("reply_expect", 32'(m_exp[ch]), 32'(re));
			end
		end
	endtask : run

	task automatic do_reset(input logic md);
		@(negedge clk);
		memdef_fitted = md;
		repeat (3) @(negedge clk);
		resetn = 1'b0;
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		if (!md) begin
			m_lvl = 4'h1;
			for (int i = 1; i <= 16; i++) begin
				m_sens[i] = 24'h0F_4240;
				m_exp[i]  = 24'h00_03E8;
			end
		end
	endtask : do_reset

	task automatic set_expd(input logic x);
		@(negedge clk);
		expanded_fitted = x;
		expd = x;
		repeat (3) @(negedge clk);
	endtask : set_expd

	initial begin
		resetn = 1'b0;
		expanded_fitted = 1'b0;
		memdef_fitted = 1'b0;
		expd = 1'b0;
		do_reset(1'b0);
		run(1'b0, 1'b1, 5'h03, 24'h00_0000);
		run(1'b1, 1'b1, 5'h10, 24'h00_0000);
		$display("Test defaults done");
		run(1'b0, 1'b0, 5'h06, 24'h00_2BC0);
		run(1'b1, 1'b0, 5'h06, 24'h00_4E20);
		run(1'b1, 1'b1, 5'h06, 24'h00_0000);
		$display("Test channel writes done");
		run(1'b1, 1'b0, 5'h02, 24'h00_2710);
		run(1'b1, 1'b0, 5'h02, 24'h00_2711);
		run(1'b0, 1'b0, 5'h04, 24'h00_1388);
		run(1'b0, 1'b0, 5'h04, 24'h00_1387);
		run(1'b0, 1'b0, 5'h04, 24'h00_0000);
		run(1'b0, 1'b0, 5'h04, 24'h00_7530);
		$display("Test range limits done");
		set_expd(1'b1);
		run(1'b1, 1'b0, 5'h02, 24'h00_2711);
		run(1'b0, 1'b0, 5'h06, 24'h00_2BC0);
		set_expd(1'b0);
		$display("Test expanded gain done");
		run(1'b0, 1'b0, 5'h00, 24'h00_0005);
		run(1'b0, 1'b1, 5'h06, 24'h00_0000);
		run(1'b0, 1'b0, 5'h00, 24'h00_000A);
		run(1'b0, 1'b0, 5'h00, 24'h00_000B);
		run(1'b0, 1'b0, 5'h00, 24'h00_0000);
		run(1'b0, 1'b0, 5'h11, 24'h00_03E8);
		run(1'b1, 1'b0, 5'h00, 24'h00_03E8);
		run(1'b0, 1'b1, 5'h00, 24'h00_0000);
		$display("Test rack level done");
		do_reset(1'b1);
		run(1'b1, 1'b1, 5'h06, 24'h00_0000);
		do_reset(1'b0);
		run(1'b1, 1'b1, 5'h06, 24'h00_0000);
		$display("Test storage over reset done");
		print_verdict();
	end

endmodule : channel_gain_normalizer_tb
